// ==== src/rsbtc_top.sv ====
// Overview of operation
// - delay strap picks extra half-clocks: 00=3, 01=2, 10=1, 11=0
// - table search strobes normally assert on first falling edge, S1
// - translation strobes assert on falling edge plus configured delay
// - fast-search strap low: searches use the same delayed edge
// - fast-search strap high: searches assert undelayed at S1
// - early startup strap high: exception startup overlaps arbitration
// - early strap low: startup waits for grant ack, six clocks more
// - early mode holds grant out for all eight clocks of the drain
// - inhibit strap high: cache inhibit asserted on own bus cycles
// - straps latched from low data byte as reset releases
// - data bus disable active while reset is asserted
// - delay shifts address strobe, bus error, halt, request out
`timescale 1ns/1ns
module rsbtc_top
	import rsbtc_pkg::*;
(
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic [rsbtc_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic [2:0]                     s_axi_awprot,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [rsbtc_pkg::DATA_W-1:0]   s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic      [1:0]                     s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [rsbtc_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic [2:0]                     s_axi_arprot,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic      [rsbtc_pkg::DATA_W-1:0]   s_axi_rdata,
	output logic      [1:0]                     s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	input  wire logic [rsbtc_pkg::STRAP_W-1:0]  data_in,
	output logic                                data_bus_disable,
	input  wire logic                           cycle_start,
	input  wire logic                           cycle_search,
	input  wire logic                           cycle_own,
	input  wire logic                           cycle_end,
	input  wire logic [rsbtc_pkg::REQ_W-1:0]    ctrl_req,
	input  wire logic                           exc_detect,
	input  wire logic                           service_done,
	input  wire logic                           logical_request_in,
	input  wire logic                           logical_grant_in,
	output logic                                phys_addr_strobe,
	output logic                                bus_error,
	output logic                                halt_out,
	output logic                                logical_request_out,
	output logic                                cache_inhibit_out,
	output logic                                logical_grant_out,
	output logic                                logical_grant_ack,
	output logic                                exc_ready
);
	import rsbtc_pkg::*;

	logic [SYNC_W-1:0]  sync_q;
	logic [STRAP_W-1:0] data_s;
	logic               req_in_s;
	logic               grant_in_s;

	rsbtc_sync2 #(.W(SYNC_W)) u_sync (
		.aclk (aclk),
		.d    ({logical_grant_in, logical_request_in, data_in}),
		.q    (sync_q)
	);
	assign data_s     = sync_q[STRAP_W-1:0];
	assign req_in_s   = sync_q[STRAP_W];
	assign grant_in_s = sync_q[STRAP_W+1];

	// strap capture
	logic [STRAP_W-1:0] strap_r,  strap_nxt;
	logic               first_r,  first_nxt;
	logic               dbd_r,    dbd_nxt;
	logic [1:0]         dly_code;
	logic               fast_search;
	logic               early_start;
	logic               inh_own;

	always_comb begin
		strap_nxt = strap_r;
		first_nxt = 1'b0;
		dbd_nxt   = 1'b0;
		if (first_r) begin
			strap_nxt = data_s;
		end
		if (!aresetn) begin
			strap_nxt = STRAP_RESET;
			first_nxt = 1'b1;
			dbd_nxt   = 1'b1;
		end
	end

	// straps only load in the first cycle after release
	always_ff @(posedge aclk) begin
		strap_r <= strap_nxt;
		first_r <= first_nxt;
		dbd_r   <= dbd_nxt;
	end

	assign dly_code    = {strap_r[STRAP_DLY_HI], strap_r[STRAP_DLY_LO]};
	assign fast_search = strap_r[STRAP_FAST];
	assign early_start = strap_r[STRAP_EARLY];
	assign inh_own     = strap_r[STRAP_INH];

	// control register
	logic [1:0] ctrl_r;
	logic       strobe_en;
	logic       grant_en;
	assign strobe_en = ctrl_r[CTRL_STROBE_EN];
	assign grant_en  = ctrl_r[CTRL_GRANT_EN];

	// strobe scheduler, one aclk per half-clock
	rsbtc_sched_e     s_st_r,  s_st_nxt;
	logic [1:0]       dly_r,   dly_nxt;
	logic             phase_r, phase_nxt;
	logic             act_r,   act_nxt;
	logic [REQ_W-1:0] stb_r,   stb_nxt;
	logic             inh_r,   inh_nxt;

	always_comb begin
		s_st_nxt  = s_st_r;
		dly_nxt   = dly_r;
		phase_nxt = ~phase_r;
		act_nxt   = act_r;
		unique case (s_st_r)
			S_IDLE: begin
				if (cycle_start) begin
					s_st_nxt = S_WAIT;
					act_nxt  = 1'b1;
					if (cycle_search && fast_search) begin
						dly_nxt = 2'h0;
					end else begin
						dly_nxt = DLY_HALF[dly_code];
					end
				end
			end
			S_WAIT: begin
				// falling edge of S1
				if (phase_r) begin
					if (dly_r == 2'h0) begin
						s_st_nxt = S_ACT;
					end else begin
						s_st_nxt = S_DLY;
						dly_nxt  = dly_r - 2'h1;
					end
				end
			end
			S_DLY: begin
				if (dly_r == 2'h0) begin
					s_st_nxt = S_ACT;
				end else begin
					dly_nxt = dly_r - 2'h1;
				end
			end
			S_ACT: begin
				s_st_nxt = S_ACT;
			end
		endcase
		if (cycle_end && s_st_r != S_IDLE) begin
			s_st_nxt = S_IDLE;
			act_nxt  = 1'b0;
		end
		stb_nxt = '0;
		if (s_st_nxt == S_ACT && strobe_en) begin
			stb_nxt = ctrl_req;
		end
		inh_nxt = act_nxt && cycle_own && inh_own;
		if (!aresetn) begin
			s_st_nxt  = S_IDLE;
			dly_nxt   = 2'h0;
			phase_nxt = 1'b0;
			act_nxt   = 1'b0;
			stb_nxt   = '0;
			inh_nxt   = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		s_st_r  <= s_st_nxt;
		dly_r   <= dly_nxt;
		phase_r <= phase_nxt;
		act_r   <= act_nxt;
		stb_r   <= stb_nxt;
		inh_r   <= inh_nxt;
	end

	// exception hardware and logical bus arbitration
	rsbtc_exc_e       e_st_r,  e_st_nxt;
	logic [CNT_W-1:0] e_cnt_r, e_cnt_nxt;
	logic             own_r,   own_nxt;
	logic             rdy_r,   rdy_nxt;
	logic             gnt_r,   gnt_nxt;
	logic             lreq_r,  lreq_nxt;
	logic             arb_req;

	always_comb begin
		e_st_nxt  = e_st_r;
		e_cnt_nxt = e_cnt_r;
		rdy_nxt   = 1'b0;
		arb_req   = (e_st_r == E_ARB) ||
			(e_st_r == E_START && early_start && !own_r);
		own_nxt   = own_r || (arb_req && grant_in_s);
		unique case (e_st_r)
			E_IDLE: begin
				if (exc_detect) begin
					if (early_start) begin
						e_st_nxt  = E_START;
						e_cnt_nxt = STARTUP_CYC;
					end else begin
						e_st_nxt = E_ARB;
					end
				end
			end
			E_ARB: begin
				if (grant_in_s) begin
					if (early_start) begin
						e_st_nxt = E_RUN;
						rdy_nxt  = 1'b1;
					end else begin
						e_st_nxt  = E_START;
						e_cnt_nxt = STARTUP_CYC;
					end
				end
			end
			E_START: begin
				if (e_cnt_r == '0) begin
					if (own_nxt) begin
						e_st_nxt = E_RUN;
						rdy_nxt  = 1'b1;
					end else begin
						e_st_nxt = E_ARB;
					end
				end else begin
					e_cnt_nxt = e_cnt_r - CNT_W'(1);
				end
			end
			E_RUN: begin
				if (service_done) begin
					e_st_nxt  = E_DRAIN;
					e_cnt_nxt = IDLE_CYC;
					own_nxt   = 1'b0;
				end
			end
			E_DRAIN: begin
				if (e_cnt_r == '0) begin
					e_st_nxt = E_IDLE;
				end else begin
					e_cnt_nxt = e_cnt_r - CNT_W'(1);
				end
			end
			default: begin
				e_st_nxt = E_IDLE;
				own_nxt  = 1'b0;
			end
		endcase
		// grant pass-through waits for idle only in early mode
		gnt_nxt = grant_en && req_in_s && grant_in_s && !own_r &&
			!arb_req && (!early_start || e_st_r == E_IDLE);
		lreq_nxt = stb_nxt[REQ_LREQ] || arb_req ||
			(req_in_s && !own_r);
		if (!aresetn) begin
			e_st_nxt  = E_IDLE;
			e_cnt_nxt = '0;
			own_nxt   = 1'b0;
			rdy_nxt   = 1'b0;
			gnt_nxt   = 1'b0;
			lreq_nxt  = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		e_st_r  <= e_st_nxt;
		e_cnt_r <= e_cnt_nxt;
		own_r   <= own_nxt;
		rdy_r   <= rdy_nxt;
		gnt_r   <= gnt_nxt;
		lreq_r  <= lreq_nxt;
	end

	// axi4-lite slave
	logic              awr_r,   awr_nxt;
	logic              bv_r,    bv_nxt;
	logic [1:0]        bresp_r, bresp_nxt;
	logic              arr_r,   arr_nxt;
	logic              rv_r,    rv_nxt;
	logic [1:0]        rresp_r, rresp_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic [1:0]        ctrl_nxt;
	logic [DATA_W-1:0] status_w;

	assign status_w = {23'h0, rdy_r, own_r, inh_r, e_st_r,
		s_st_r, first_r};

	always_comb begin
		awr_nxt   = s_axi_awvalid && s_axi_wvalid && !awr_r && !bv_r;
		bv_nxt    = bv_r && !s_axi_bready;
		bresp_nxt = bresp_r;
		ctrl_nxt  = ctrl_r;
		if (awr_r) begin
			bv_nxt    = 1'b1;
			bresp_nxt = RESP_SLVERR;
			if (s_axi_awaddr == REG_CTRL) begin
				bresp_nxt = RESP_OKAY;
				if (s_axi_wstrb[0]) begin
					ctrl_nxt = s_axi_wdata[1:0];
				end
			end
		end
		arr_nxt   = s_axi_arvalid && !arr_r && !rv_r;
		rv_nxt    = rv_r && !s_axi_rready;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (arr_r) begin
			rv_nxt    = 1'b1;
			rresp_nxt = RESP_OKAY;
			unique case (s_axi_araddr)
				REG_STRAPS: rdata_nxt = {24'h0, strap_r};
				REG_STATUS: rdata_nxt = status_w;
				REG_CTRL:   rdata_nxt = {30'h0, ctrl_r};
				default: begin
					rdata_nxt = '0;
					rresp_nxt = RESP_SLVERR;
				end
			endcase
		end
		if (!aresetn) begin
			awr_nxt   = 1'b0;
			bv_nxt    = 1'b0;
			bresp_nxt = RESP_OKAY;
			ctrl_nxt  = CTRL_RESET;
			arr_nxt   = 1'b0;
			rv_nxt    = 1'b0;
			rresp_nxt = RESP_OKAY;
			rdata_nxt = '0;
		end
	end

	always_ff @(posedge aclk) begin
		awr_r   <= awr_nxt;
		bv_r    <= bv_nxt;
		bresp_r <= bresp_nxt;
		ctrl_r  <= ctrl_nxt;
		arr_r   <= arr_nxt;
		rv_r    <= rv_nxt;
		rresp_r <= rresp_nxt;
		rdata_r <= rdata_nxt;
	end

	assign s_axi_awready       = awr_r;
	assign s_axi_wready        = awr_r;
	assign s_axi_bvalid        = bv_r;
	assign s_axi_bresp         = bresp_r;
	assign s_axi_arready       = arr_r;
	assign s_axi_rvalid        = rv_r;
	assign s_axi_rresp         = rresp_r;
	assign s_axi_rdata         = rdata_r;
	assign data_bus_disable    = dbd_r;
	assign phys_addr_strobe    = stb_r[REQ_ASTB];
	assign bus_error           = stb_r[REQ_FAIL];
	assign halt_out            = stb_r[REQ_HALT];
	assign logical_request_out = lreq_r;
	assign cache_inhibit_out   = inh_r;
	assign logical_grant_out   = gnt_r;
	assign logical_grant_ack   = own_r;
	assign exc_ready           = rdy_r;
endmodule

// ==== common/rsbtc_pkg.sv ====
package rsbtc_pkg;

	// bus and strap widths
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int STRAP_W = 8;
	localparam int REQ_W   = 4;
	localparam int CNT_W   = 5;
	localparam int SYNC_W  = STRAP_W + 2;

	// strap bit positions in the low data byte
	localparam int STRAP_DLY_LO = 3;
	localparam int STRAP_DLY_HI = 4;
	localparam int STRAP_FAST   = 5;
	localparam int STRAP_EARLY  = 6;
	localparam int STRAP_INH    = 7;

	// floating pins read as ones
	localparam logic [STRAP_W-1:0] STRAP_RESET = 8'hFF;

	// control request vector positions
	localparam int REQ_ASTB = 0;
	localparam int REQ_FAIL = 1;
	localparam int REQ_HALT = 2;
	localparam int REQ_LREQ = 3;

	// one bus clock is two aclk cycles (one per half-clock)
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_HALVES    = 2;
	localparam int STARTUP_CLKS  = 6;
	localparam int IDLE_CLKS     = 8;
	localparam int LATE_SAVE_CLKS = 7;
	localparam logic [CNT_W-1:0] STARTUP_CYC =
		CNT_W'(STARTUP_CLKS * CLK_HALVES - 1);
	localparam logic [CNT_W-1:0] IDLE_CYC =
		CNT_W'(IDLE_CLKS * CLK_HALVES - 1);

	// extra decision delay in half-clocks, indexed by {d4,d3}
	localparam logic [1:0] DLY_HALF [4] = '{2'h3, 2'h2, 2'h1, 2'h0};

	// register map
	localparam logic [ADDR_W-1:0] REG_STRAPS = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h08;
	localparam int CTRL_STROBE_EN = 0;
	localparam int CTRL_GRANT_EN  = 1;
	localparam logic [1:0] CTRL_RESET = 2'h3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		S_IDLE = 2'h0,
		S_WAIT = 2'h1,
		S_DLY  = 2'h3,
		S_ACT  = 2'h2
	} rsbtc_sched_e;

	typedef enum logic [2:0] {
		E_IDLE  = 3'h0,
		E_ARB   = 3'h1,
		E_START = 3'h3,
		E_RUN   = 3'h2,
		E_DRAIN = 3'h6
	} rsbtc_exc_e;

endpackage

// ==== src/rsbtc_sync2.sv ====
`timescale 1ns/1ns
module rsbtc_sync2 #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// free-running so straps are tracked while reset is held
	always_ff @(posedge aclk) begin
		meta_r <= d;
		q      <= meta_r;
	end
endmodule

// ==== tb/rsbtc_arb_model.sv ====
`timescale 1ns/1ns
module rsbtc_arb_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [3:0] lat,
	input  wire logic       logical_request_out,
	output logic            logical_grant_in
);
	logic [3:0] cnt_r;

	// grants lat+1 cycles after the request, drops with it
	always_ff @(posedge aclk) begin
		if (!aresetn || !logical_request_out) begin
			cnt_r <= 4'h0;
			logical_grant_in <= 1'b0;
		end else if (cnt_r == lat) begin
			logical_grant_in <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule

// ==== tb/rsbtc_checker.sv ====
`timescale 1ns/1ns
module rsbtc_checker
	import rsbtc_pkg::*;
(
	input wire logic                          aclk,
	input wire logic                          aresetn,
	input wire logic [rsbtc_pkg::STRAP_W-1:0] data_in,
	input wire logic                          data_bus_disable,
	input wire logic                          cycle_own,
	input wire logic                          cycle_end,
	input wire logic [rsbtc_pkg::REQ_W-1:0]   ctrl_req,
	input wire logic                          phys_addr_strobe,
	input wire logic                          bus_error,
	input wire logic                          halt_out,
	input wire logic                          cache_inhibit_out,
	input wire logic                          logical_grant_out,
	input wire logic                          logical_grant_ack,
	input wire logic                          exc_ready
);
	logic [STRAP_W-1:0] d1_r, d2_r, strap_r;
	logic               rel_r;

	// straps as seen through the synchroniser at release
	always_ff @(posedge aclk) begin
		d1_r <= data_in;
		d2_r <= d1_r;
		rel_r <= aresetn;
		if (aresetn && !rel_r) begin
			strap_r <= d2_r;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_DISABLE_ON: assert property (disable iff (1'b0)
		!aresetn |=> data_bus_disable) else $error("disable low in reset");
	AST_DISABLE_OFF: assert property ($past(aresetn) |->
		!data_bus_disable) else $error("disable high after reset");
	AST_END_DROP: assert property (cycle_end |=>
		!(phys_addr_strobe | bus_error | halt_out))
		else $error("strobe after cycle end");
	AST_ASTB_REQ: assert property ($rose(phys_addr_strobe) |->
		$past(ctrl_req[REQ_ASTB])) else $error("strobe without request");
	AST_STB_SET: assert property ($rose(phys_addr_strobe) |->
		{halt_out, bus_error} == $past(ctrl_req[REQ_HALT:REQ_FAIL]))
		else $error("strobe set mismatch");
	AST_INHIBIT: assert property (cache_inhibit_out |->
		$past(cycle_own) && strap_r[STRAP_INH])
		else $error("cache inhibit wrong");
	AST_LATE: assert property ($rose(logical_grant_ack) &&
		!strap_r[STRAP_EARLY] |-> !exc_ready [*8])
		else $error("ready too soon");
	AST_DRAIN: assert property ($fell(logical_grant_ack) &&
		strap_r[STRAP_EARLY] |-> !logical_grant_out [*8])
		else $error("grant during drain");
	AST_RDY_PULSE: assert property (exc_ready |=> !exc_ready)
		else $error("ready too long");

	cover property ($rose(phys_addr_strobe));
	cover property ($rose(exc_ready));
	cover property ($rose(logical_grant_out));
endmodule

bind rsbtc_top rsbtc_checker u_chk (.aclk, .aresetn, .data_in,
	.data_bus_disable, .cycle_own, .cycle_end, .ctrl_req,
	.phys_addr_strobe, .bus_error, .halt_out, .cache_inhibit_out,
	.logical_grant_out, .logical_grant_ack, .exc_ready);

// ==== tb/tb_rsbtc_top.sv ====
`timescale 1ns/1ns
module tb_rsbtc_top;
	import rsbtc_pkg::*;
	logic               aclk, aresetn, cycle_start, cycle_search;
	logic               cycle_own, cycle_end, exc_detect, service_done;
	logic               logical_request_in, logical_grant_in;
	logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic               s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic               s_axi_rready, data_bus_disable, phys_addr_strobe;
	logic               bus_error, halt_out, logical_request_out;
	logic               cache_inhibit_out, logical_grant_out;
	logic               logical_grant_ack, exc_ready;
	logic [ADDR_W-1:0]  s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0]  s_axi_wdata, s_axi_rdata;
	logic [1:0]         s_axi_bresp, s_axi_rresp;
	logic [STRAP_W-1:0] data_in, st;
	logic [REQ_W-1:0]   ctrl_req;
	logic [3:0]         lat, s_axi_wstrb;
	int                 errors, check_count, n, cyc, ns, nt;

	rsbtc_top u_dut (.s_axi_awprot(3'h0),
		.s_axi_arprot(3'h0), .*);
	rsbtc_arb_model u_arb (.*);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cyc <= aresetn ? cyc + 1 : 0;
	end

	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED %0t got %0h exp %0h", $time, got, exp);
		end
	endtask

	task automatic tk(input int k);
		repeat (k) @(posedge aclk);
	endtask

	task automatic wt(ref logic s);
		for (n = 1; n < 200; n++) begin
			@(posedge aclk);
			if (s === 1'b1) break;
		end
		chk(n < 200, 1);
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (n = 0; s_axi_bvalid !== 1'b1 && n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk(n < 50, 1);
		chk(s_axi_bresp, r);
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] r);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (n = 0; s_axi_rvalid !== 1'b1 && n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk(n < 50, 1);
		chk(s_axi_rdata, d);
		chk(s_axi_rresp, r);
		@(posedge aclk);
	endtask

	task automatic do_reset(input logic [7:0] s);
		st = s;
		data_in <= s;
		aresetn <= 1'b0;
		tk(5);
		chk(data_bus_disable, 1);
		aresetn <= 1'b1;
		tk(3);
		chk(data_bus_disable, 0);
		axi_rd(REG_STRAPS, 32'(s), RESP_OKAY);
	endtask

	task automatic run_cyc(input logic srch, output int lat_o);
		while (!cyc[0]) @(posedge aclk);
		cycle_search <= srch;
		cycle_start <= 1'b1;
		@(posedge aclk);
		cycle_start <= 1'b0;
		wt(phys_addr_strobe);
		lat_o = n;
		chk({bus_error, halt_out, logical_request_out},
			{ctrl_req[REQ_FAIL], ctrl_req[REQ_HALT], ctrl_req[REQ_LREQ]});
		chk(cache_inhibit_out, st[STRAP_INH] & cycle_own);
		cycle_end <= 1'b1;
		@(posedge aclk);
		cycle_end <= 1'b0;
		tk(2);
		chk(phys_addr_strobe, 0);
	endtask

	task automatic run_exc(input logic early);
		exc_detect <= 1'b1;
		@(posedge aclk);
		exc_detect <= 1'b0;
		wt(logical_grant_ack);
		wt(exc_ready);
		chk(n >= 11, !early);
		service_done <= 1'b1;
		logical_request_in <= 1'b1;
		@(posedge aclk);
		service_done <= 1'b0;
		wt(logical_grant_out);
		chk(n >= 16, early);
		logical_request_in <= 1'b0;
		tk(8);
		chk(logical_grant_out, 0);
	endtask

	task automatic t_mask();
		axi_rd(REG_CTRL, 32'h3, RESP_OKAY);
		s_axi_wstrb <= 4'h0;
		axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
		axi_rd(REG_CTRL, 32'h3, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
		cycle_start <= 1'b1;
		logical_request_in <= 1'b1;
		@(posedge aclk);
		cycle_start <= 1'b0;
		tk(10);
		chk(phys_addr_strobe, 0);
		chk(logical_grant_out, 0);
		cycle_end <= 1'b1;
		logical_request_in <= 1'b0;
		@(posedge aclk);
		cycle_end <= 1'b0;
		axi_wr(REG_CTRL, 32'h3, RESP_OKAY);
		ctrl_req <= 4'h5;
		cycle_own <= 1'b0;
		run_cyc(1'b0, nt);
		chk(nt, 3);
		ctrl_req <= 4'hF;
		cycle_own <= 1'b1;
		axi_wr(REG_STRAPS, 32'h0, RESP_SLVERR);
		axi_rd(8'h40, 32'h0, RESP_SLVERR);
		data_in <= ~st;
		tk(4);
		axi_rd(REG_STRAPS, 32'(st), RESP_OKAY);
	endtask

	initial begin
		{cycle_start, cycle_search, cycle_end, exc_detect} = 4'h0;
		{service_done, logical_request_in, cycle_own} = 3'h1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		ctrl_req = 4'hF;
		s_axi_wstrb = 4'hF;
		lat = 4'h0;
		errors = 0;
		check_count = 0;
		cyc = 0;
		for (int c = 3; c >= 0; c--) begin
			do_reset({3'h5, 2'(c), 3'h7});
			run_cyc(1'b1, ns);
			run_cyc(1'b0, nt);
			chk(ns, 2);
			chk(nt - ns, 3 - c);
			do_reset({3'h2, 2'(c), 3'h7});
			run_cyc(1'b1, ns);
			run_cyc(1'b0, nt);
			chk(ns, nt);
		end
		lat <= 4'h5;
		run_exc(1'b1);
		do_reset(8'h97);
		lat <= 4'h0;
		run_exc(1'b0);
		t_mask();
		end_of_test();
	end

	initial begin
		#100us;
		errors++;
		end_of_test();
	end
endmodule
